// ===== logic/limit_switch_reaction.v
// limit switch fault reaction with its object registers
`default_nettype none
`include "limit_switch_reaction_defs.vh"

module limit_switch_reaction (
   input wire clock_in,
   input wire rst_in,
   input wire limit_switch_in,
   input wire [15:0] obj_addr_in,
   input wire obj_wr_in,
   input wire obj_rd_in,
   input wire [31:0] obj_wdata_in,
   input wire [31:0] eeprom_size_in,
   input wire ramp_done_in,
   input wire [15:0] control_word_in,
   input wire warning_clear_in,
   output reg [31:0] obj_rdata_out,
   output reg obj_rvalid_out,
   output reg obj_error_out,
   output reg warning_out,
   output reg brake_slow_out,
   output reg brake_quick_out,
   output reg go_switch_on_disabled_out,
   output reg go_quick_stop_active_out,
   output reg motor_energized_out,
   output reg return_op_enabled_out,
   output reg [31:0] hw_config_out
);
   // one-hot reaction states
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_BRAKE = 5'h02;
   localparam [4:0] ST_DISABLED = 5'h04;
   localparam [4:0] ST_QSTOP = 5'h08;
   localparam [4:0] ST_QSTOP_ARMED = 5'h10;

   // object registers and sequencer state
   reg [15:0] limit_reaction_code;
   reg [31:0] eeprom_size_bytes;
   reg [4:0] state;
   reg to_qstop;
   // synchroniser taps and the limit edge
   reg lim_prev;
   wire [1:0] pin_raw;
   wire [1:0] pin_sync;
   wire lim_sync;
   wire ramp_sync;
   wire lim_rise;

   // true for codes that start a braking reaction
   function is_active_code;
      input [15:0] code;
      begin
         is_active_code = (code == `CODE_SLOW_DISABLE) || (code == `CODE_QUICK_DISABLE) ||
            (code == `CODE_SLOW_QSTOP) || (code == `CODE_QUICK_QSTOP);
      end
   endfunction

   // pins gathered so one loop builds both synchronisers
   assign pin_raw = {ramp_done_in, limit_switch_in};
   assign lim_sync = pin_sync[0];
   assign ramp_sync = pin_sync[1];

   // two-stage synchroniser per pin; only the second stage reads the first
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         reg first_ff;
         reg second_ff;
         always @(posedge clock_in) begin
            if (rst_in) begin
               first_ff <= 1'b0;
               second_ff <= 1'b0;
            end else begin
               first_ff <= pin_raw[gi];
               second_ff <= first_ff;
            end
         end
         assign pin_sync[gi] = second_ff;
      end
   endgenerate

   // last synced level for the edge detector, reset to the idle low pin
   always @(posedge clock_in) begin
      if (rst_in) begin
         lim_prev <= 1'b0;
      end else begin
         lim_prev <= lim_sync;
      end
   end

   // one-cycle strobe on the synced rising edge
   assign lim_rise = lim_sync & ~lim_prev;

   // object register access
   always @(posedge clock_in) begin
      if (rst_in) begin
         limit_reaction_code <= `RST_LIMIT_REACTION_CODE;
         eeprom_size_bytes <= `RST_EEPROM_SIZE_BYTES;
         hw_config_out <= `RST_HARDWARE_CONFIG_WORD;
         obj_rdata_out <= 32'h00000000;
         obj_rvalid_out <= 1'b0;
         obj_error_out <= 1'b0;
      end else begin
         eeprom_size_bytes <= eeprom_size_in;
         obj_rvalid_out <= obj_rd_in;
         obj_error_out <= 1'b0;
         obj_rdata_out <= 32'h00000000;
         if (obj_wr_in) begin
            if (obj_addr_in == `ADDR_LIMIT_REACTION_CODE) begin
               limit_reaction_code <= obj_wdata_in[15:0];
            end else if (obj_addr_in == `ADDR_HARDWARE_CONFIG_WORD) begin
               hw_config_out <= obj_wdata_in;
            end else begin
               obj_error_out <= 1'b1; // read-only or unmapped
            end
         end else if (obj_rd_in) begin
            if (obj_addr_in == `ADDR_LIMIT_REACTION_CODE) begin
               obj_rdata_out <= {16'h0000, limit_reaction_code};
            end else if (obj_addr_in == `ADDR_EEPROM_SIZE_BYTES) begin
               obj_rdata_out <= eeprom_size_bytes;
            end else if (obj_addr_in == `ADDR_HARDWARE_CONFIG_WORD) begin
               obj_rdata_out <= hw_config_out;
            end else begin
               obj_error_out <= 1'b1;
            end
         end
      end
   end

   // warning flag, set wins over clear
   always @(posedge clock_in) begin
      if (rst_in) begin
         warning_out <= 1'b0;
      end else if (lim_rise) begin
         warning_out <= 1'b1;
      end else if (warning_clear_in) begin
         warning_out <= 1'b0;
      end
   end

   // reaction sequencer
   always @(posedge clock_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
         to_qstop <= 1'b0;
         brake_slow_out <= 1'b0;
         brake_quick_out <= 1'b0;
         go_switch_on_disabled_out <= 1'b0;
         go_quick_stop_active_out <= 1'b0;
         motor_energized_out <= 1'b1;
         return_op_enabled_out <= 1'b0;
      end else begin
         go_switch_on_disabled_out <= 1'b0;
         go_quick_stop_active_out <= 1'b0;
         return_op_enabled_out <= 1'b0;
         case (state)
            ST_IDLE: begin
               // reserved and -1 codes fall through untouched
               if (lim_rise && is_active_code(limit_reaction_code)) begin
                  state <= ST_BRAKE;
                  brake_slow_out <= (limit_reaction_code == `CODE_SLOW_DISABLE) ||
                     (limit_reaction_code == `CODE_SLOW_QSTOP);
                  brake_quick_out <= (limit_reaction_code == `CODE_QUICK_DISABLE) ||
                     (limit_reaction_code == `CODE_QUICK_QSTOP);
                  to_qstop <= (limit_reaction_code == `CODE_SLOW_QSTOP) ||
                     (limit_reaction_code == `CODE_QUICK_QSTOP);
               end
            end
            ST_BRAKE: begin
               // brake levels stand until the synced standstill
               if (ramp_sync) begin
                  brake_slow_out <= 1'b0;
                  brake_quick_out <= 1'b0;
                  if (to_qstop) begin
                     state <= ST_QSTOP;
                     go_quick_stop_active_out <= 1'b1;
                  end else begin
                     state <= ST_DISABLED;
                     go_switch_on_disabled_out <= 1'b1;
                     motor_energized_out <= 1'b0;
                  end
               end
            end
            ST_DISABLED: begin
               // back to idle and motor re-energized as soon as the synced limit pin drops
               if (!lim_sync) begin
                  state <= ST_IDLE;
                  motor_energized_out <= 1'b1;
               end
            end
            ST_QSTOP: begin
               // control bit 2 is not forced; wait for master to drop it
               if (!control_word_in[`CONTROL_QUICK_STOP_BIT]) begin
                  state <= ST_QSTOP_ARMED;
               end
            end
            ST_QSTOP_ARMED: begin
               if (control_word_in[`CONTROL_QUICK_STOP_BIT]) begin
                  state <= ST_IDLE;
                  return_op_enabled_out <= 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // limit_switch_reaction
`default_nettype wire

// ===== logic/limit_switch_reaction_defs.vh
// constants for the limit switch reaction block
`ifndef LIMIT_SWITCH_REACTION_DEFS_VH
`define LIMIT_SWITCH_REACTION_DEFS_VH
`define ADDR_LIMIT_REACTION_CODE 16'h3701
`define ADDR_EEPROM_SIZE_BYTES 16'h4012
`define ADDR_HARDWARE_CONFIG_WORD 16'h4013
`define RST_LIMIT_REACTION_CODE 16'hffff
`define RST_EEPROM_SIZE_BYTES 32'h00000000
`define RST_HARDWARE_CONFIG_WORD 32'h00000000
`define CODE_NONE 16'hffff
`define CODE_SLOW_DISABLE 16'h0001
`define CODE_QUICK_DISABLE 16'h0002
`define CODE_SLOW_QSTOP 16'h0005
`define CODE_QUICK_QSTOP 16'h0006
`define STATUS_WARNING_BIT 7
`define CONTROL_QUICK_STOP_BIT 2
`endif

// ===== verification/limit_switch_reaction_checker.sv
// port assertions for the limit switch reaction block
`default_nettype none
module limit_switch_reaction_checker (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic limit_switch_in,
   input wire logic obj_wr_in,
   input wire logic obj_rd_in,
   input wire logic ramp_done_in,
   input wire logic [15:0] control_word_in,
   input wire logic obj_rvalid_out,
   input wire logic warning_out,
   input wire logic brake_slow_out,
   input wire logic brake_quick_out,
   input wire logic go_switch_on_disabled_out,
   input wire logic go_quick_stop_active_out,
   input wire logic motor_energized_out,
   input wire logic return_op_enabled_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // pin seen low then high while quiet
   sequence limit_edge;
      !limit_switch_in ##1 limit_switch_in;
   endsequence
   warn_set_a: assert property (limit_edge ##0 !warning_out && !brake_slow_out
      && !brake_quick_out |-> ##3 warning_out) else $error("warning not set after limit");
   brake_excl_a: assert property (!(brake_slow_out && brake_quick_out))
      else $error("both ramps active");
   brake_warn_a: assert property (brake_slow_out || brake_quick_out |-> warning_out)
      else $error("braking without warning");
   rd_answer_a: assert property (obj_rd_in && !obj_wr_in |=> obj_rvalid_out)
      else $error("read not answered");
   rvalid_cause_a: assert property (obj_rvalid_out |-> $past(obj_rd_in))
      else $error("stray read valid");
   qsa_energ_a: assert property (go_quick_stop_active_out |-> motor_energized_out)
      else $error("motor off entering quick stop");
   sod_off_a: assert property (go_switch_on_disabled_out |-> ##[0:1] !motor_energized_out)
      else $error("motor still on when disabled");
   state_ramp_a: assert property (go_quick_stop_active_out || go_switch_on_disabled_out
      |-> $past(ramp_done_in, 3)) else $error("state change before standstill");
   ret_qs_a: assert property (return_op_enabled_out |-> $past(control_word_in[2]))
      else $error("return without quick stop bit high");
endmodule // limit_switch_reaction_checker
`default_nettype wire

// ===== verification/fieldbus_master_model.sv
// fieldbus master model driving the control word
`default_nettype none
module fieldbus_master_model (
   input wire logic clock_in,
   input wire logic toggle_in,
   output logic [15:0] control_word_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] hold = 2'h0;
   // on request drop quick stop bit, then raise it again, updated after the rising edge
   always @(posedge clock_in) begin
      if (toggle_in) begin
         hold <= 2'h2;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
      end
   end
   assign control_word_out = {12'h000, 1'b1, hold == 2'h0, 2'h3};
endmodule // fieldbus_master_model
`default_nettype wire

// ===== verification/limit_switch_reaction_tb.sv
// bench for the limit switch reaction block
`default_nettype none
`include "limit_switch_reaction_defs.vh"
module limit_switch_reaction_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 0, rst_in = 1, lim = 0, wr = 0, rd = 0, ramp = 0, wclr = 0, tog = 0;
   logic [15:0] addr = 16'h0000, cw, c;
   logic [31:0] wdata = 32'h0, eeprom = 32'h0, rdata, hw;
   logic rvalid, err, warn, bslow, bquick, sod, qsa, energ, ret, s, q;
   logic [2:0] seen = 3'h0;
   logic seen_clr = 0;
   int failures = 0, cmp_count = 0, cycles = 0;
   logic [15:0] codes [6] = '{16'hffff, 16'h0001, 16'h0002, 16'h0005, 16'h0006, 16'h0003};
   limit_switch_reaction dut (.clock_in(clock_in), .rst_in(rst_in), .limit_switch_in(lim),
      .obj_addr_in(addr), .obj_wr_in(wr), .obj_rd_in(rd), .obj_wdata_in(wdata),
      .eeprom_size_in(eeprom), .ramp_done_in(ramp), .control_word_in(cw),
      .warning_clear_in(wclr), .obj_rdata_out(rdata), .obj_rvalid_out(rvalid),
      .obj_error_out(err), .warning_out(warn), .brake_slow_out(bslow),
      .brake_quick_out(bquick), .go_switch_on_disabled_out(sod),
      .go_quick_stop_active_out(qsa), .motor_energized_out(energ),
      .return_op_enabled_out(ret), .hw_config_out(hw));
   fieldbus_master_model master (.clock_in(clock_in), .toggle_in(tog), .control_word_out(cw));
   initial forever #5 clock_in = ~clock_in;
   // catch one-cycle pulses and cut a hang short
   always @(posedge clock_in) begin
      seen <= seen_clr ? 3'h0 : (seen | {ret, qsa, sod});
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures++;
         finish_test();
      end
   end
   task automatic check(input string what, input logic [32:0] got, input logic [32:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one object access, then error flag and read data compared
   task automatic xfer(string what, logic w, logic [15:0] a, logic [31:0] d, logic [32:0] exp);
      @(negedge clock_in);
      wr = w;
      rd = !w;
      addr = a;
      wdata = d;
      @(negedge clock_in);
      wr = 0;
      rd = 0;
      check(what, {err, rdata}, exp);
      check(what, rvalid, !w);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clock_in);
      rst_in = 0;
      xfer("code reset", 0, `ADDR_LIMIT_REACTION_CODE, 0, 33'h0_0000ffff);
      xfer("eeprom none", 0, `ADDR_EEPROM_SIZE_BYTES, 0, 33'h0);
      xfer("hwcfg reset", 0, `ADDR_HARDWARE_CONFIG_WORD, 0, 33'h0);
      eeprom = 32'h00008000;
      xfer("eeprom write", 1, `ADDR_EEPROM_SIZE_BYTES, 32'h1, 33'h1_00000000);
      xfer("eeprom read", 0, `ADDR_EEPROM_SIZE_BYTES, 0, 33'h0_00008000);
      xfer("hwcfg write", 1, `ADDR_HARDWARE_CONFIG_WORD, 32'ha5a50f0f, 33'h0);
      xfer("hwcfg read", 0, `ADDR_HARDWARE_CONFIG_WORD, 0, 33'h0_a5a50f0f);
      check("hwcfg pins", {1'b0, hw}, 33'h0_a5a50f0f);
      xfer("unmapped", 0, 16'h3702, 0, 33'h1_00000000);
      // every code: limit hit, ramp finished, quick stop toggled
      foreach (codes[i]) begin
         c = codes[i];
         s = c == 16'h0001 || c == 16'h0002;
         q = c == 16'h0005 || c == 16'h0006;
         seen_clr = 1;
         xfer("code write", 1, `ADDR_LIMIT_REACTION_CODE, {16'h0000, c}, 33'h0);
         seen_clr = 0;
         lim = 1;
         repeat (6) @(negedge clock_in);
         check("warning", warn, 1'b1);
         check("brakes", {bslow, bquick}, {c[0] & (s | q), ~c[0] & (s | q)});
         ramp = 1;
         repeat (5) @(negedge clock_in);
         check("state", {seen[1:0], energ}, {q, s, ~s});
         tog = 1;
         repeat (2) @(negedge clock_in);
         tog = 0;
         repeat (6) @(negedge clock_in);
         check("return", {seen[2], bslow, bquick}, {q, 2'b00});
         lim = 0;
         ramp = 0;
         wclr = 1;
         @(negedge clock_in);
         wclr = 0;
         repeat (4) @(negedge clock_in);
         check("warning cleared", warn, 1'b0);
         check("energized again", energ, 1'b1);
      end
      finish_test();
   end
endmodule // limit_switch_reaction_tb
bind limit_switch_reaction limit_switch_reaction_checker chk (.clock_in, .rst_in,
   .limit_switch_in, .obj_wr_in, .obj_rd_in, .ramp_done_in, .control_word_in, .obj_rvalid_out,
   .warning_out, .brake_slow_out, .brake_quick_out, .go_switch_on_disabled_out,
   .go_quick_stop_active_out, .motor_energized_out, .return_op_enabled_out);
`default_nettype wire
